// ---- rtl/cis_pkg.sv ----
// Package for the counter interrupt status and acknowledge block.
// Assumes a 16-bit host I/O port with byte and word accesses.
package cis_pkg;

    ////////////////////////////////////////////////////////////////////////
    // Register offsets inside the board's I/O window
    localparam logic [3:0] CIS_OFS_STATUS_LO = 4'h6; // Status two / clear
    localparam logic [3:0] CIS_OFS_STATUS_HI = 4'h7; // Upper byte alias

    // Channel count and byte geometry
    localparam int CIS_NUM_CH    = 2;
    localparam int CIS_BYTE_W    = 8;
    localparam int CIS_WORD_W    = 16;

    ////////////////////////////////////////////////////////////////////////
    // Status two field positions inside one channel byte
    localparam int CIS_ST_OVERFLOW   = 0;
    localparam int CIS_ST_SIG_ONE    = 1;
    localparam int CIS_ST_SIG_THREE  = 2;
    localparam int CIS_ST_COMPARE    = 3;
    localparam int CIS_ST_GATE       = 4;

    // Clear register field positions inside one channel byte
    localparam int CIS_ACK_ZERO_MARK = 0;
    localparam int CIS_ACK_SIG_ZERO  = 1;
    localparam int CIS_ACK_SIG_TWO   = 2;
    localparam int CIS_ACK_SIG_ONE   = 3;
    localparam int CIS_ACK_SIG_THREE = 4;
    localparam int CIS_ACK_OVERFLOW  = 5;
    localparam int CIS_ACK_COMPARE   = 6;

    // Reset values
    localparam logic [15:0] CIS_RDATA_RST = 16'h0000;
    localparam logic [7:0]  CIS_BYTE_ZERO = 8'h00;

    ////////////////////////////////////////////////////////////////////////
    // Events arriving from one counting channel (one-cycle pulses)
    typedef struct packed {
        logic zeroMark;     // Zero-mark pulse seen
        logic sigZero;      // Special signal zero fired
        logic sigTwo;       // Special signal two fired
        logic sigOne;       // Special signal one fired
        logic sigThree;     // Special signal three fired
        logic overflow;     // Counter overflowed
        logic compareEqual; // Counter equals compare value
    } cis_event_s;

    // Interrupt enables of one channel, held in control registers outside
    typedef struct packed {
        logic zeroMark;
        logic sigZero;
        logic sigTwo;
        logic sigOne;
        logic sigThree;
        logic overflow;
        logic compare;
    } cis_enable_s;

    // Latched state of one channel
    typedef struct packed {
        logic zeroMark;     // Zero-mark latch
        logic sigZero;      // Signal zero status in status register 0
        logic alarm;        // Alarm status in status register 0
        logic sigOne;       // Signal one flag in status two
        logic sigThree;     // Signal three flag in status two
        logic ovLatch;      // Overflow latch in status two
        logic ovRequest;    // Pending overflow interrupt request
        logic compare;      // Compare-match flag in status two
    } cis_chan_s;

    localparam cis_chan_s CIS_CHAN_RST = '0;

endpackage

// ---- rtl/cis_counter_irq_status_clear.sv ----
// Interrupt status and acknowledge logic for a two-channel counter board.
// Assumes synchronous event pulses from the counting channels and a host
// I/O port whose strobes last one mclk cycle per access.
//
// What this block does
// - Status bit 8 latches channel 1 overflow until reset-alarm command.
// - Status bit 9 latches channel 1 signal one requests, ignoring enable.
// - Status bit 10 latches ch 1 signal three requests, ignoring enable.
// - Status bit 11 latches channel 1 compare match until acknowledged.
// - Status bit 12 shows channel 1 gate open state live.
// - Clear writes act on each bit written one; zeros ignored.
// - Clear bit 0 drops channel 0 zero-mark request and latch.
// - Clear bit 1 drops channel 0 signal zero request and status.
// - Clear bit 2 drops channel 0 signal two request and alarm.
// - Clear bit 3 drops channel 0 signal one request and flag.
// - Clear bit 4 drops channel 0 signal three request and flag.
// - Clear bit 5 drops channel 0 overflow interrupt request.
// - Clear bit 6 drops channel 0 compare request and flag.
// - Clear bit 8 drops channel 1 zero-mark request and latch.
// - Clear bit 9 drops channel 1 signal zero request and status.
// - Clear bit 10 drops channel 1 signal two request and alarm.
// - Clear bit 11 drops channel 1 signal one request and flag.
// - Clear bit 12 drops channel 1 signal three request and flag.
// - Clear bit 13 drops channel 1 overflow interrupt request.
// - Clear bit 14 drops channel 1 compare request and flag.
// - Status two accepts word reads and single byte reads.
// - Low status byte mirrors channel 0 fields in same order.
module cis_counter_irq_status_clear
    import cis_pkg::*;
#(
    parameter int ADDR_W = 4
) (
    // Clock and reset
    input  wire logic                  mclk,
    input  wire logic                  resetn,
    // Host I/O port
    input  wire logic [ADDR_W-1:0]     ioAddr,
    input  wire logic                  ioRead,
    input  wire logic                  ioWrite,
    input  wire logic                  ioWord,
    input  wire logic [15:0]           ioWdata,
    output logic      [15:0]           ioRdata,
    output logic                       ioRdValid,
    // Channel events, enables and levels
    input  wire cis_event_s            chEvent     [CIS_NUM_CH],
    input  wire cis_enable_s           chEnable    [CIS_NUM_CH],
    input  wire logic [CIS_NUM_CH-1:0] gateOpen,
    input  wire logic [CIS_NUM_CH-1:0] countRead,
    input  wire logic                  resetAlarmCmd,
    // Latched state seen by the other status registers
    output cis_chan_s                  chState     [CIS_NUM_CH],
    // Interrupt request lines
    output logic                       irqZeroMark,
    output logic                       irqSpecialSignals,
    output logic                       irqCh0Group,
    output logic                       irqCh1Group,
    output logic                       irqCh0Compare,
    output logic                       irqCh1Compare
);

    ////////////////////////////////////////////////////////////////////////
    // Elaboration checks
    if (ADDR_W < 3) begin : gAddrCheck
        $error("ADDR_W too small to reach the status offsets");
    end
    // The status layout packs exactly one byte per channel
    if (CIS_NUM_CH != 2) begin : gChCheck
        $error("Block serves exactly two channels");
    end

    ////////////////////////////////////////////////////////////////////////
    // Address decode helpers

    // Offset match, shared by the read and write paths
    // Only the low address bits are compared; the board base decode
    // sits in the host interface outside this block
    function automatic logic hitsOffset(input logic [ADDR_W-1:0] a,
                                        input logic [3:0]        ofs);
        hitsOffset = (a == ADDR_W'(ofs));
    endfunction

    // True when the access touches the given byte lane of the register
    function automatic logic laneHit(input logic [ADDR_W-1:0] a,
                                     input logic              word,
                                     input int                lane);
        logic lo;
        logic hi;
        lo = hitsOffset(a, CIS_OFS_STATUS_LO);
        hi = hitsOffset(a, CIS_OFS_STATUS_HI);
        if (word) begin
            laneHit = lo;
        end else begin
            laneHit = (lane == 0) ? lo : hi;
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Clear strobes per channel byte
    logic [CIS_BYTE_W-1:0] ackByte [CIS_NUM_CH];

    // Writes never store anything; they only fire one-cycle clears
    // A word write at the high offset matches no lane and is dropped
    always_comb begin
        for (int c = 0; c < CIS_NUM_CH; c++) begin
            ackByte[c] = CIS_BYTE_ZERO;
            if (ioWrite && laneHit(ioAddr, ioWord, c)) begin
                if (ioWord) begin
                    ackByte[c] = ioWdata[c*CIS_BYTE_W +: CIS_BYTE_W];
                end else begin
                    // Byte writes carry data on the low lane
                    ackByte[c] = ioWdata[CIS_BYTE_W-1:0];
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Per-channel latches; an event in the clear cycle wins over the clear
    // Hazard: a pulse landing with its own clear would otherwise be lost
    cis_chan_s chan      [CIS_NUM_CH];
    cis_chan_s next_chan [CIS_NUM_CH];

    for (genvar c = 0; c < CIS_NUM_CH; c++) begin : gChan
        always_comb begin
            next_chan[c] = chan[c];
            // Only bits written as one act; bit 7 has no meaning
            // Zero-mark: ack bit or a counting register read
            if (ackByte[c][CIS_ACK_ZERO_MARK] || countRead[c]) begin
                next_chan[c].zeroMark = 1'b0;
            end
            if (ackByte[c][CIS_ACK_SIG_ZERO]) begin
                next_chan[c].sigZero = 1'b0;
            end
            if (ackByte[c][CIS_ACK_SIG_TWO]) begin
                next_chan[c].alarm = 1'b0;
            end
            if (ackByte[c][CIS_ACK_SIG_ONE]) begin
                next_chan[c].sigOne = 1'b0;
            end
            if (ackByte[c][CIS_ACK_SIG_THREE]) begin
                next_chan[c].sigThree = 1'b0;
            end
            if (ackByte[c][CIS_ACK_OVERFLOW]) begin
                next_chan[c].ovRequest = 1'b0;
            end
            // Overflow latch outlives the request: only reset-alarm clears
            if (resetAlarmCmd) begin
                next_chan[c].ovLatch = 1'b0;
            end
            if (ackByte[c][CIS_ACK_COMPARE]) begin
                next_chan[c].compare = 1'b0;
            end
            // Set terms last so they win; enables do not gate the flags
            if (chEvent[c].zeroMark) begin
                next_chan[c].zeroMark = 1'b1;
            end
            if (chEvent[c].sigZero) begin
                next_chan[c].sigZero = 1'b1;
            end
            if (chEvent[c].sigTwo) begin
                next_chan[c].alarm = 1'b1;
            end
            if (chEvent[c].sigOne) begin
                next_chan[c].sigOne = 1'b1;
            end
            if (chEvent[c].sigThree) begin
                next_chan[c].sigThree = 1'b1;
            end
            if (chEvent[c].overflow) begin
                next_chan[c].ovLatch   = 1'b1;
                next_chan[c].ovRequest = 1'b1;
            end
            if (chEvent[c].compareEqual) begin
                next_chan[c].compare = 1'b1;
            end
        end

        // Plain register stage; all decisions sit in the process above
        always_ff @(posedge mclk or negedge resetn) begin
            if (!resetn) begin
                chan[c] <= CIS_CHAN_RST;
            end else begin
                chan[c] <= next_chan[c];
            end
        end

        assign chState[c] = chan[c];
    end

    ////////////////////////////////////////////////////////////////////////
    // Status two byte of one channel, same layout for both halves
    // Bits above the gate always read as zero
    function automatic logic [CIS_BYTE_W-1:0] statusByte(
        input cis_chan_s s,
        input logic      gate
    );
        statusByte                   = CIS_BYTE_ZERO;
        statusByte[CIS_ST_OVERFLOW]  = s.ovLatch;
        statusByte[CIS_ST_SIG_ONE]   = s.sigOne;
        statusByte[CIS_ST_SIG_THREE] = s.sigThree;
        statusByte[CIS_ST_COMPARE]   = s.compare;
        statusByte[CIS_ST_GATE]      = gate;
    endfunction

    // Read data, captured on the read strobe
    // Trade-off: registered data costs one cycle but keeps outputs clean
    logic [15:0] next_ioRdata;
    logic        next_ioRdValid;
    logic [15:0] statusWord;

    // Gate state is sampled at the read itself, never latched
    always_comb begin
        statusWord = {statusByte(chan[1], gateOpen[1]),
                      statusByte(chan[0], gateOpen[0])};
        next_ioRdata   = CIS_RDATA_RST;
        next_ioRdValid = 1'b0;
        if (ioRead) begin
            if (ioWord && hitsOffset(ioAddr, CIS_OFS_STATUS_LO)) begin
                next_ioRdata   = statusWord;
                next_ioRdValid = 1'b1;
            end else if (!ioWord &&
                         hitsOffset(ioAddr, CIS_OFS_STATUS_LO)) begin
                next_ioRdata   = {CIS_BYTE_ZERO,
                                  statusWord[CIS_BYTE_W-1:0]};
                next_ioRdValid = 1'b1;
            end else if (!ioWord &&
                         hitsOffset(ioAddr, CIS_OFS_STATUS_HI)) begin
                // Upper half delivered on the low lane, 8-bit style
                next_ioRdata   = {CIS_BYTE_ZERO,
                                  statusWord[CIS_WORD_W-1:CIS_BYTE_W]};
                next_ioRdValid = 1'b1;
            end
        end
    end

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            ioRdata   <= CIS_RDATA_RST;
            ioRdValid <= 1'b0;
        end else begin
            ioRdata   <= next_ioRdata;
            ioRdValid <= next_ioRdValid;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Interrupt lines: pending state gated by the outside enables
    // Limitation: a flag latched while its enable is off raises its
    // line as soon as software turns the enable on
    logic next_irqZeroMark;
    logic next_irqSpecial;
    logic next_irqCh0Group;
    logic next_irqCh1Group;
    logic next_irqCh0Compare;
    logic next_irqCh1Compare;

    // Group lines for one channel: signal one, signal three, overflow
    // Overflow uses the request, not the latch, so its ack drops the line
    function automatic logic groupReq(input cis_chan_s   s,
                                      input cis_enable_s e);
        groupReq = (s.sigOne   & e.sigOne)   |
                   (s.sigThree & e.sigThree) |
                   (s.ovRequest & e.overflow);
    endfunction

    // Registered so every line comes straight from a flip-flop
    always_comb begin
        next_irqZeroMark = 1'b0;
        next_irqSpecial  = 1'b0;
        for (int c = 0; c < CIS_NUM_CH; c++) begin
            next_irqZeroMark = next_irqZeroMark |
                               (chan[c].zeroMark & chEnable[c].zeroMark);
            next_irqSpecial  = next_irqSpecial |
                               (chan[c].sigZero & chEnable[c].sigZero) |
                               (chan[c].alarm   & chEnable[c].sigTwo);
        end
        next_irqCh0Group   = groupReq(chan[0], chEnable[0]);
        next_irqCh1Group   = groupReq(chan[1], chEnable[1]);
        next_irqCh0Compare = chan[0].compare & chEnable[0].compare;
        next_irqCh1Compare = chan[1].compare & chEnable[1].compare;
    end

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            irqZeroMark       <= 1'b0;
            irqSpecialSignals <= 1'b0;
            irqCh0Group       <= 1'b0;
            irqCh1Group       <= 1'b0;
            irqCh0Compare     <= 1'b0;
            irqCh1Compare     <= 1'b0;
        end else begin
            irqZeroMark       <= next_irqZeroMark;
            irqSpecialSignals <= next_irqSpecial;
            irqCh0Group       <= next_irqCh0Group;
            irqCh1Group       <= next_irqCh1Group;
            irqCh0Compare     <= next_irqCh0Compare;
            irqCh1Compare     <= next_irqCh1Compare;
        end
    end

endmodule

// ---- tb/cis_counter_irq_status_clear_chk.sv ----
// Checker for the counter interrupt status and acknowledge block.
// Assumes it is bound to the design top and sees only its ports.
module cis_counter_irq_status_clear_chk
    import cis_pkg::*;
#(
    parameter int ADDR_W = 4
) (
    // Clock and reset
    input wire logic                  mclk,
    input wire logic                  resetn,
    // Host port
    input wire logic [ADDR_W-1:0]     ioAddr,
    input wire logic                  ioRead,
    input wire logic                  ioWrite,
    input wire logic                  ioWord,
    input wire logic [15:0]           ioWdata,
    input wire logic [15:0]           ioRdata,
    input wire logic                  ioRdValid,
    // Channel side
    input wire cis_event_s            chEvent  [CIS_NUM_CH],
    input wire cis_enable_s           chEnable [CIS_NUM_CH],
    input wire logic [CIS_NUM_CH-1:0] gateOpen,
    input wire logic                  resetAlarmCmd,
    input wire cis_chan_s             chState  [CIS_NUM_CH],
    input wire logic                  irqCh1Compare
);
    logic        lo;
    logic        hi;
    logic [15:0] clr;

    ////////////////////////////////////////////////////////////////////////
    // Acknowledge bits a write carries; a word write at 7 does nothing
    always_comb begin
        lo = (ioAddr == ADDR_W'(CIS_OFS_STATUS_LO));
        hi = (ioAddr == ADDR_W'(CIS_OFS_STATUS_HI));
        clr = 16'h0000;
        if (ioWrite && lo)
            clr = ioWord ? ioWdata : {8'h00, ioWdata[7:0]};
        else if (ioWrite && hi && !ioWord)
            clr = {ioWdata[7:0], 8'h00};
    end

    default clocking cb @(posedge mclk); endclocking
    default disable iff (!resetn);

    ////////////////////////////////////////////////////////////////////////
    // Status latches, acknowledges and the read path
    a_rd_hit_valid: assert property (
        ioRead && !ioWord && (lo || hi) |=> ioRdValid)
        else $error("read hit gave no data");
    a_rd_miss_quiet: assert property (
        (!ioRead || !(lo || hi)) |=> !ioRdValid)
        else $error("data without a read hit");
    a_ovf_sets_both: assert property (
        chEvent[1].overflow |=> chState[1].ovLatch && chState[1].ovRequest)
        else $error("overflow not latched");
    a_ovf_latch_hold: assert property (
        chState[1].ovLatch && !resetAlarmCmd |=> chState[1].ovLatch)
        else $error("overflow latch dropped");
    a_sig_one_set: assert property (
        chEvent[1].sigOne && !chEnable[1].sigOne |=> chState[1].sigOne)
        else $error("signal one not latched");
    a_sig_three_set: assert property (
        chEvent[1].sigThree |=> chState[1].sigThree)
        else $error("signal three not latched");
    a_cmp_flag_hold: assert property (
        chState[1].compare && !clr[14] |=> chState[1].compare)
        else $error("compare flag dropped");
    a_gate_live_read: assert property (
        ioRead && !ioWord && hi |=>
            ioRdata[CIS_ST_GATE] == $past(gateOpen[1]))
        else $error("gate bit wrong");
    a_ack_sig_one: assert property (
        clr[11] && !chEvent[1].sigOne |=> !chState[1].sigOne)
        else $error("signal one ack ignored");
    a_ack_ovf_req: assert property (
        clr[5] && !chEvent[0].overflow |=> !chState[0].ovRequest)
        else $error("overflow ack ignored");
    a_low_byte_ovf: assert property (
        ioRead && ioWord && lo |=>
            ioRdata[0] == $past(chState[0].ovLatch))
        else $error("low byte wrong");
    a_cmp_irq_follow: assert property (
        chState[1].compare && chEnable[1].compare |=> irqCh1Compare)
        else $error("compare request missing");

    // Main scenarios reached
    c_read_done: cover property (ioRdValid);
    c_cmp_irq: cover property (chState[1].compare ##1 irqCh1Compare);
    c_alarm_cmd: cover property (resetAlarmCmd);
endmodule

bind cis_counter_irq_status_clear cis_counter_irq_status_clear_chk #(
    .ADDR_W(ADDR_W)
) i_chk (
    .mclk(mclk), .resetn(resetn), .ioAddr(ioAddr), .ioRead(ioRead),
    .ioWrite(ioWrite), .ioWord(ioWord), .ioWdata(ioWdata),
    .ioRdata(ioRdata), .ioRdValid(ioRdValid), .chEvent(chEvent),
    .chEnable(chEnable), .gateOpen(gateOpen), .resetAlarmCmd(resetAlarmCmd),
    .chState(chState), .irqCh1Compare(irqCh1Compare)
);

// ---- tb/cis_counter_irq_status_clear_bench.sv ----
// Self-checking bench for the counter interrupt status and acknowledge block.
// Assumes the package, the design and its checker are compiled first.
module cis_counter_irq_status_clear_bench import cis_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;

    logic        mclk = 1'b0;
    logic        resetn = 1'b0;
    logic [3:0]  ioAddr = 4'h0;
    logic        ioRead = 1'b0;
    logic        ioWrite = 1'b0;
    logic        ioWord = 1'b0;
    logic [15:0] ioWdata = 16'h0000;
    logic [15:0] ioRdata;
    logic        ioRdValid;
    cis_event_s  chEvent  [CIS_NUM_CH] = '{default: '0};
    cis_enable_s chEnable [CIS_NUM_CH] = '{default: '0};
    cis_chan_s   chState  [CIS_NUM_CH];
    logic [1:0]  gateOpen = 2'h0;
    logic [1:0]  countRead = 2'h0;
    logic        resetAlarmCmd = 1'b0;
    logic [5:0]  irq;
    logic [15:0] d;
    logic        v;
    int          miscompares = 0;
    int          testsRun = 0;

    cis_counter_irq_status_clear i_cis_counter_irq_status_clear (
        .mclk(mclk), .resetn(resetn), .ioAddr(ioAddr), .ioRead(ioRead),
        .ioWrite(ioWrite), .ioWord(ioWord), .ioWdata(ioWdata),
        .ioRdata(ioRdata), .ioRdValid(ioRdValid), .chEvent(chEvent),
        .chEnable(chEnable), .gateOpen(gateOpen), .countRead(countRead),
        .resetAlarmCmd(resetAlarmCmd), .chState(chState),
        .irqZeroMark(irq[0]), .irqSpecialSignals(irq[1]),
        .irqCh0Group(irq[2]), .irqCh1Group(irq[3]),
        .irqCh0Compare(irq[4]), .irqCh1Compare(irq[5])
    );

    // 100 MHz clock
    always #5 mclk = ~mclk;

    ////////////////////////////////////////////////////////////////////////
    // Shared bus, event and compare tasks
    task automatic check(input string what, input logic [15:0] seen,
                         input logic [15:0] exp);
        testsRun++;
        if (seen !== exp) begin
            miscompares++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // One-cycle read strobe; data taken at the edge after the strobe
    task automatic busRead(input logic [3:0] a, input logic w);
        @(posedge mclk);
        #1;
        ioAddr = a;
        ioWord = w;
        ioRead = 1'b1;
        @(posedge mclk);
        #1;
        d = ioRdata;
        v = ioRdValid;
        ioRead = 1'b0;
    endtask

    task automatic busWrite(input logic [3:0] a, input logic w,
                            input logic [15:0] data);
        @(posedge mclk);
        #1;
        ioAddr = a;
        ioWord = w;
        ioWdata = data;
        ioWrite = 1'b1;
        @(posedge mclk);
        #1;
        ioWrite = 1'b0;
    endtask

    // All event pulses of both channels for one cycle
    task automatic fireAll;
        @(posedge mclk);
        #1;
        chEvent = '{default: '1};
        @(posedge mclk);
        #1;
        chEvent = '{default: '0};
    endtask

    // Latched field hit by acknowledge bit k of one channel byte
    function automatic logic [7:0] ackMask(input int k);
        return (k < 5) ? (8'h80 >> k) : (8'h02 >> (k - 5));
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Scenarios
    task automatic testStatus;
        busRead(4'h3, 1'b0);
        check("miss valid", {15'h0, v}, 16'h0000);
        fireAll();
        gateOpen = 2'h2;
        busWrite(4'h6, 1'b1, 16'h8080);
        busRead(4'h7, 1'b0);
        check("hi byte", d, 16'h001f);
        busRead(4'h6, 1'b1);
        check("word", d, 16'h1f0f);
        busRead(4'h6, 1'b0);
        check("lo byte", d, 16'h000f);
        check("group off", {15'h0, irq[3]}, 16'h0000);
        chEnable[1].compare = 1'b1;
        repeat (2) @(posedge mclk);
        #1;
        check("cmp irq", {15'h0, irq[5]}, 16'h0001);
        @(posedge mclk);
        #1;
        resetAlarmCmd = 1'b1;
        @(posedge mclk);
        #1;
        resetAlarmCmd = 1'b0;
        gateOpen = 2'h0;
        busRead(4'h7, 1'b0);
        check("alarm cmd", d, 16'h000e);
        $display("testStatus done");
    endtask

    // Each acknowledge bit clears its own field and nothing else
    task automatic testClear;
        for (int k = 0; k < 7; k++) begin
            fireAll();
            busWrite(4'h6, 1'b1, 16'h0001 << k);
            check("ch0", 16'(chState[0]), {8'h0, 8'hff & ~ackMask(k)});
            check("ch1 kept", 16'(chState[1]), 16'h00ff);
            fireAll();
            busWrite(4'h7, 1'b0, 16'h0001 << k);
            check("ch1", 16'(chState[1]), {8'h0, 8'hff & ~ackMask(k)});
            check("ch0 kept", 16'(chState[0]), 16'h00ff);
        end
        $display("testClear done");
    endtask

    // Enabled flags raise every line; each clear drops only its own lines
    task automatic testIrq;
        chEnable = '{default: '1};
        fireAll();
        repeat (2) @(posedge mclk);
        #1;
        check("irq all", {10'h0, irq}, 16'h003f);
        countRead = 2'h3;
        @(posedge mclk);
        #1;
        countRead = 2'h0;
        @(posedge mclk);
        #1;
        check("irq zero mark", {10'h0, irq}, 16'h003e);
        busWrite(4'h6, 1'b1, 16'h0606);
        @(posedge mclk);
        #1;
        check("irq special", {10'h0, irq}, 16'h003c);
        busWrite(4'h6, 1'b1, 16'h3838);
        @(posedge mclk);
        #1;
        check("irq group", {10'h0, irq}, 16'h0030);
        busWrite(4'h6, 1'b1, 16'h4040);
        @(posedge mclk);
        #1;
        check("irq compare", {10'h0, irq}, 16'h0000);
        busRead(4'h6, 1'b1);
        check("word valid", {15'h0, v}, 16'h0001);
        check("ovf latch kept", d, 16'h0101);
        $display("testIrq done");
    endtask

    ////////////////////////////////////////////////////////////////////////
    // Verdict, watchdog and main sequence
    task automatic completeRun;
        $display("comparisons %0d mismatches %0d", testsRun, miscompares);
        if (miscompares == 0 && testsRun > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    // Whole run is about 110 cycles; far margin before giving up
    initial begin
        #100us;
        miscompares++;
        completeRun();
    end

    initial begin
        repeat (20) @(posedge mclk);
        #1;
        resetn = 1'b1;
        testStatus();
        testIrq();
        testClear();
        completeRun();
    end
endmodule
